/* design/bxcl_pkg.sv */
// Package for the byte-wide express configuration loader.
// Assumes a system clock domain and a link domain on config_clock.
package bxcl_pkg;
    localparam logic [7:0] BXCL_FILL = 8'hff;
    // Stream bytes written with bus line 0 as leftmost bit
    localparam logic [7:0] BXCL_PREAMBLE = 8'h4f;   // 11110010b reversed
    localparam logic [7:0] BXCL_CHECK = 8'h4b;      // 11010010b reversed
    localparam logic [6:0] BXCL_START = 7'h3f;      // 1111110b reversed
    localparam logic [2:0] BXCL_MODE_EXPRESS = 3'h2;
    localparam logic [2:0] BXCL_HDR_LAST = 3'h6;
    localparam logic [7:0] BXCL_FRAME_BYTES = 8'h04; // Data bytes per frame
    localparam logic [7:0] BXCL_FRAME_COUNT = 8'h03;
    localparam logic [3:0] BXCL_STARTUP_CLKS = 4'h6;
    localparam logic [7:0] BXCL_ZERO8 = 8'h00;
    localparam logic [7:0] BXCL_ONE8 = 8'h01;
    localparam logic [2:0] BXCL_ONE3 = 3'h1;
    localparam logic [3:0] BXCL_ONE4 = 4'h1;
    localparam logic [1:0] BXCL_ONE2 = 2'h1;
    typedef enum logic [2:0] {
        BXCL_HDR, BXCL_WAIT, BXCL_FSTART, BXCL_FDATA, BXCL_FCHECK,
        BXCL_STARTUP, BXCL_DONE, BXCL_ERROR
    } bxcl_state_e;
    // Status passed from link domain to system domain
    typedef struct packed {
        logic error;
        logic done;
        logic full;
        logic hdr_done;
    } bxcl_status_s;
endpackage

/* design/bxcl_sync.sv */
// Two flip-flop level synchroniser, one per bit.
// Assumes the input is a level from another clock domain.
`timescale 1ns/10ps
`default_nettype none
module bxcl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* design/bxcl_loader.sv */
// Byte-wide express configuration loader top.
// Assumes the source drives config_clock and config_byte_bus; open-drain
// pins are pulled up outside.
`timescale 1ns/10ps
`default_nettype none
module bxcl_loader (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic config_clock,
    input wire logic program_n,
    input wire logic mode_sel_2,
    input wire logic mode_sel_1,
    input wire logic mode_sel_0,
    input wire logic chain_select,
    input wire logic [7:0] config_byte_bus,
    input wire logic init_n_in,
    input wire logic done_in,
    output logic init_n_oe,
    output logic done_oe,
    output logic chain_status,
    output logic config_done,
    output logic config_error,
    output logic [7:0] frame_byte,
    output logic frame_byte_valid
);
    // ==========================================================
    // Link domain reset: system reset or program pulse
    // ==========================================================
    logic link_rst_n;
    logic lrst_meta_q;
    logic lrst_q;
    assign link_rst_n = rst_n & program_n;
    // Reset released synchronously to the config clock
    always_ff @(posedge config_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lrst_meta_q <= 1'b0;
            lrst_q <= 1'b0;
        end else begin
            lrst_meta_q <= 1'b1;
            lrst_q <= lrst_meta_q;
        end
    end

    // ==========================================================
    // Link domain parser
    // ==========================================================
    bxcl_pkg::bxcl_state_e st_q, st_d;
    logic [2:0] hcnt_q, hcnt_d;
    logic [7:0] bcnt_q, bcnt_d;
    logic [7:0] fcnt_q, fcnt_d;
    logic [3:0] scnt_q, scnt_d;
    logic mode_q, mode_d;
    logic dout_q, dout_d;
    logic [1:0] wp_q, wp_d; // Ring write index
    logic [1:0] wg_q, wg_d; // Gray copy of the write index
    logic [7:0] ring_q [4];
    logic [7:0] ring_d [4];
    logic [7:0] hdr_exp;
    logic sel;

    // Expected header byte at each position
    always_comb begin
        unique case (hcnt_q)
            3'h2: hdr_exp = bxcl_pkg::BXCL_PREAMBLE;
            bxcl_pkg::BXCL_HDR_LAST: hdr_exp = bxcl_pkg::BXCL_CHECK;
            default: hdr_exp = bxcl_pkg::BXCL_FILL;
        endcase
    end

    // Pins read directly in link domain; source meets setup to config_clock
    assign sel = chain_select;

    // Next-state logic, one byte per rising edge
    always_comb begin
        st_d = st_q;
        hcnt_d = hcnt_q;
        bcnt_d = bcnt_q;
        fcnt_d = fcnt_q;
        scnt_d = scnt_q;
        mode_d = mode_q;
        dout_d = dout_q;
        wp_d = wp_q;
        ring_d = ring_q;
        unique case (st_q)
            bxcl_pkg::BXCL_HDR: begin
                // Mode sampled on first byte; non-express stalls in wait
                if (hcnt_q == '0) begin
                    mode_d = ({mode_sel_2, mode_sel_1, mode_sel_0} ==
                              bxcl_pkg::BXCL_MODE_EXPRESS);
                end
                if (hcnt_q == '0 && {mode_sel_2, mode_sel_1, mode_sel_0}
                        != bxcl_pkg::BXCL_MODE_EXPRESS) begin
                    st_d = bxcl_pkg::BXCL_WAIT;
                end else if (config_byte_bus != hdr_exp) begin
                    st_d = bxcl_pkg::BXCL_ERROR;
                end else if (hcnt_q == bxcl_pkg::BXCL_HDR_LAST) begin
                    st_d = bxcl_pkg::BXCL_FSTART;
                    dout_d = 1'b0;
                end else begin
                    hcnt_d = hcnt_q + bxcl_pkg::BXCL_ONE3;
                end
            end
            bxcl_pkg::BXCL_WAIT: st_d = bxcl_pkg::BXCL_WAIT;
            bxcl_pkg::BXCL_FSTART: begin
                if (sel) begin
                    if (config_byte_bus[6:0] != bxcl_pkg::BXCL_START) begin
                        st_d = bxcl_pkg::BXCL_ERROR;
                    end else begin
                        st_d = bxcl_pkg::BXCL_FDATA;
                        bcnt_d = bxcl_pkg::BXCL_ZERO8;
                    end
                end
            end
            bxcl_pkg::BXCL_FDATA: begin
                if (sel) begin
                    ring_d[wp_q] = config_byte_bus;
                    wp_d = wp_q + bxcl_pkg::BXCL_ONE2;
                    bcnt_d = bcnt_q + bxcl_pkg::BXCL_ONE8;
                    if (bcnt_q == bxcl_pkg::BXCL_FRAME_BYTES -
                            bxcl_pkg::BXCL_ONE8) begin
                        st_d = bxcl_pkg::BXCL_FCHECK;
                    end
                end
            end
            bxcl_pkg::BXCL_FCHECK: begin
                if (sel) begin
                    if (config_byte_bus != bxcl_pkg::BXCL_CHECK) begin
                        st_d = bxcl_pkg::BXCL_ERROR;
                    end else if (fcnt_q == bxcl_pkg::BXCL_FRAME_COUNT -
                            bxcl_pkg::BXCL_ONE8) begin
                        st_d = bxcl_pkg::BXCL_STARTUP;
                        dout_d = 1'b1;
                        scnt_d = '0;
                    end else begin
                        fcnt_d = fcnt_q + bxcl_pkg::BXCL_ONE8;
                        st_d = bxcl_pkg::BXCL_FSTART;
                    end
                end
            end
            bxcl_pkg::BXCL_STARTUP: begin
                // Byte values ignored, only clocks counted
                scnt_d = scnt_q + bxcl_pkg::BXCL_ONE4;
                if (scnt_q == bxcl_pkg::BXCL_STARTUP_CLKS -
                        bxcl_pkg::BXCL_ONE4) begin
                    st_d = bxcl_pkg::BXCL_DONE;
                end
            end
            bxcl_pkg::BXCL_DONE: st_d = bxcl_pkg::BXCL_DONE;
            bxcl_pkg::BXCL_ERROR: st_d = bxcl_pkg::BXCL_ERROR;
            default: st_d = bxcl_pkg::BXCL_ERROR;
        endcase
        wg_d = wp_d ^ {1'b0, wp_d[1]};
    end

    // Link registers, one byte per rising config clock edge
    always_ff @(posedge config_clock or negedge lrst_q) begin
        if (!lrst_q) begin
            st_q <= bxcl_pkg::BXCL_HDR;
            hcnt_q <= '0;
            bcnt_q <= '0;
            fcnt_q <= '0;
            scnt_q <= '0;
            mode_q <= 1'b0;
            dout_q <= 1'b1;
            wp_q <= '0;
            wg_q <= '0;
            ring_q <= '{default: '0};
        end else begin
            st_q <= st_d;
            hcnt_q <= hcnt_d;
            bcnt_q <= bcnt_d;
            fcnt_q <= fcnt_d;
            scnt_q <= scnt_d;
            mode_q <= mode_d;
            dout_q <= dout_d;
            wp_q <= wp_d;
            wg_q <= wg_d;
            ring_q <= ring_d;
        end
    end

    // ==========================================================
    // Crossing to system domain
    // ==========================================================
    bxcl_pkg::bxcl_status_s lstat, sstat;
    logic [1:0] wg_sync;
    assign lstat.error = (st_q == bxcl_pkg::BXCL_ERROR);
    assign lstat.done = (st_q == bxcl_pkg::BXCL_DONE);
    assign lstat.full = dout_q;
    assign lstat.hdr_done = (st_q != bxcl_pkg::BXCL_HDR);

    bxcl_sync #(.W(6)) u_sync_stat (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din({lstat, wg_q}),
        .dout({sstat, wg_sync})
    );

    // Gray index crosses; a ring entry stays put four bytes, long enough
    logic [1:0] rp_q, rp_d;
    logic [7:0] fbs_q, fbs_d;
    logic fbv_q, fbv_d;
    logic init_oe_q, init_oe_d;
    logic done_oe_q, done_oe_d;
    logic cs_q, cs_d;
    logic cdone_q, cdone_d;
    logic cerr_q, cerr_d;

    // System side outputs
    always_comb begin
        fbv_d = (wg_sync != (rp_q ^ {1'b0, rp_q[1]}));
        rp_d = fbv_d ? rp_q + bxcl_pkg::BXCL_ONE2 : rp_q;
        fbs_d = fbv_d ? ring_q[rp_q] : fbs_q;
        init_oe_d = sstat.error;
        done_oe_d = ~sstat.done;
        cs_d = sstat.full;
        cdone_d = sstat.done & done_in;
        cerr_d = sstat.error;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_q <= '0;
            fbs_q <= '0;
            fbv_q <= 1'b0;
            init_oe_q <= 1'b0;
            done_oe_q <= 1'b1;
            cs_q <= 1'b1;
            cdone_q <= 1'b0;
            cerr_q <= 1'b0;
        end else begin
            rp_q <= rp_d;
            fbs_q <= fbs_d;
            fbv_q <= fbv_d;
            init_oe_q <= init_oe_d;
            done_oe_q <= done_oe_d;
            cs_q <= cs_d;
            cdone_q <= cdone_d;
            cerr_q <= cerr_d;
        end
    end

    assign init_n_oe = init_oe_q;
    assign done_oe = done_oe_q;
    assign chain_status = cs_q;
    assign config_done = cdone_q;
    assign config_error = cerr_q;
    assign frame_byte = fbs_q;
    assign frame_byte_valid = fbv_q;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_error_holds: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_ERROR |=>
        st_q == bxcl_pkg::BXCL_ERROR && $stable(wp_q))
        else $error("loading resumed after error");
    chk_bad_check: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_FCHECK && sel &&
        config_byte_bus != bxcl_pkg::BXCL_CHECK |=>
        st_q == bxcl_pkg::BXCL_ERROR)
        else $error("bad check byte accepted");
    chk_hdr_error: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_HDR && mode_d &&
        config_byte_bus != hdr_exp |=> st_q == bxcl_pkg::BXCL_ERROR)
        else $error("bad header byte accepted");
    chk_no_select: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_FDATA && !sel
        |=> $stable(wp_q) && $stable(bcnt_q))
        else $error("frame byte taken without select");
    chk_mode_gate: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_HDR && hcnt_q == '0
        && {mode_sel_2, mode_sel_1, mode_sel_0} !=
        bxcl_pkg::BXCL_MODE_EXPRESS |=> st_q == bxcl_pkg::BXCL_WAIT)
        else $error("wrong mode entered loading");
    chk_status_low: assert property (@(posedge config_clock)
        disable iff (!lrst_q) (st_q == bxcl_pkg::BXCL_FSTART ||
        st_q == bxcl_pkg::BXCL_FDATA) |-> !dout_q)
        else $error("chain status high during frames");
    chk_status_hdr: assert property (@(posedge config_clock)
        disable iff (!lrst_q) st_q == bxcl_pkg::BXCL_HDR |-> dout_q)
        else $error("chain status low during header");
    chk_init_err: assert property (@(posedge sys_clk)
        disable iff (!rst_n) init_n_oe |-> config_error)
        else $error("init pulled low without error");
endmodule
`default_nettype wire

/* bench/bxcl_source.sv */
// Behavioural configuration source that drives the loader's link side.
// Assumes the bench calls one task at a time; clock parks low between bytes.
`timescale 1ns/10ps
`default_nettype none
module bxcl_source (
    output var logic config_clock,
    output var logic [7:0] config_byte_bus
);
    // ========================================
    // Link clock and byte drive
    initial begin
        config_clock = 1'b0;
        config_byte_bus = 8'h00;
    end
    // Stream leftmost bit goes to bus line 0
    function automatic logic [7:0] rev8(input logic [7:0] b);
        return {<<{b}};
    endfunction
    // One byte taken per rising edge, bus inverted once the edge is past
    task automatic send(input logic [7:0] b);
        config_byte_bus = b;
        #24 config_clock = 1'b1;
        #24 config_clock = 1'b0;
        config_byte_bus = ~b;
    endtask
    // Clock edges that carry no stream data
    task automatic idle(input int n);
        repeat (n) send(~config_byte_bus);
    endtask
    // Seven header bytes with a chosen preamble
    task automatic header(input logic [7:0] pre);
        logic [7:0] h [7];
        h = '{8'hff, 8'hff, pre, 8'hff, 8'hff, 8'hff, rev8(8'b11010010)};
        foreach (h[i]) send(h[i]);
    endtask
    // Start field, four data bytes, then a check byte
    task automatic frame(input logic [7:0] first, input logic [7:0] chk);
        send({1'b1, 7'h3f});
        for (int k = 0; k < 4; k++) send(first + 8'(k));
        send(chk);
    endtask
endmodule
`default_nettype wire

/* bench/bxcl_loader_bench.sv */
// Self-checking bench for the configuration loader.
// Assumes pulled-up open-drain pins, resolved here from the enables.
`timescale 1ns/10ps
`default_nettype none
module bxcl_loader_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic program_n = 1'b1;
    logic [2:0] mode = 3'h2;
    logic chain_select = 1'b1;
    logic other_done_pull = 1'b0;
    wire config_clock;
    wire [7:0] config_byte_bus;
    wire init_pin_n = ~init_n_oe;
    wire done_pin = ~(done_oe | other_done_pull);
    wire mode_pin_2 = mode[2];
    wire mode_pin_1 = mode[1];
    wire mode_pin_0 = mode[0];
    logic init_n_oe, done_oe, chain_status, config_done, config_error;
    logic frame_byte_valid;
    logic [7:0] frame_byte;
    logic [7:0] good_chk;
    logic [7:0] got [$];
    int n_mismatch = 0;
    int num_checks = 0;
    // ========================================
    // Clock, parts and open-drain wiring
    always #20 sys_clk = ~sys_clk;
    bxcl_source src (.config_clock(config_clock),
        .config_byte_bus(config_byte_bus));
    bxcl_loader DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .config_clock(config_clock), .program_n(program_n),
        .mode_sel_2(mode_pin_2), .mode_sel_1(mode_pin_1),
        .mode_sel_0(mode_pin_0),
        .chain_select(chain_select), .config_byte_bus(config_byte_bus),
        .init_n_in(init_pin_n), .done_in(done_pin),
        .init_n_oe(init_n_oe), .done_oe(done_oe),
        .chain_status(chain_status), .config_done(config_done),
        .config_error(config_error), .frame_byte(frame_byte),
        .frame_byte_valid(frame_byte_valid));
    // Collect every frame byte the loader hands out
    always @(posedge sys_clk) begin
        if (frame_byte_valid === 1'b1) got.push_back(frame_byte);
    end
    // ========================================
    // Compare, settle and restart helpers
    task automatic cmp_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask
    // Program pulse restarts the link side, then two non-data edges
    task automatic restart();
        @(posedge sys_clk) program_n <= 1'b0;
        src.idle(2);
        @(posedge sys_clk) program_n <= 1'b1;
        src.idle(2);
        settle();
        got.delete();
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        cmp_bit(init_n_oe, 1'b0);
        cmp_bit(done_oe, 1'b1);
        cmp_bit(chain_status, 1'b1);
        cmp_bit(config_done, 1'b0);
        $display("t_reset done");
    endtask
    task automatic t_good();
        restart();
        src.header(src.rev8(8'b11110010));
        settle();
        cmp_bit(chain_status, 1'b0);
        @(posedge sys_clk) chain_select <= 1'b0;
        src.frame(8'h80, good_chk);
        settle();
        cmp_byte(8'(got.size()), 8'h00);
        @(posedge sys_clk) chain_select <= 1'b1;
        other_done_pull <= 1'b1;
        for (int f = 0; f < 3; f++) src.frame(8'h10 * 8'(f + 1), good_chk);
        settle();
        cmp_bit(chain_status, 1'b1);
        cmp_byte(8'(got.size()), 8'h0c);
        foreach (got[i]) cmp_byte(got[i], 8'h10 * 8'(i / 4 + 1) + 8'(i % 4));
        src.frame(8'h90, 8'h00);
        src.idle(2);
        settle();
        cmp_byte(8'(got.size()), 8'h0c);
        cmp_bit(done_oe, 1'b0);
        cmp_bit(config_done, 1'b0);
        cmp_bit(config_error, 1'b0);
        @(posedge sys_clk) other_done_pull <= 1'b0;
        settle();
        cmp_bit(config_done, 1'b1);
        $display("t_good done");
    endtask
    task automatic t_bad_check();
        int n;
        restart();
        src.header(src.rev8(8'b11110010));
        src.frame(8'h20, 8'h00);
        settle();
        cmp_bit(init_n_oe, 1'b1);
        cmp_bit(config_error, 1'b1);
        n = got.size();
        src.frame(8'h30, good_chk);
        settle();
        cmp_byte(8'(got.size()), 8'(n));
        restart();
        cmp_bit(init_n_oe, 1'b0);
        cmp_bit(config_error, 1'b0);
        $display("t_bad_check done");
    endtask
    task automatic t_bad_header();
        restart();
        src.header(8'h00);
        settle();
        cmp_bit(init_n_oe, 1'b1);
        cmp_bit(config_error, 1'b1);
        $display("t_bad_header done");
    endtask
    task automatic t_mode();
        for (int m = 0; m < 8; m++) begin
            if (m != 2) begin
                @(posedge sys_clk) mode <= 3'(m);
                restart();
                src.header(src.rev8(8'b11110010));
                src.frame(8'h40, good_chk);
                settle();
                cmp_bit(chain_status, 1'b1);
                cmp_byte(8'(got.size()), 8'h00);
            end
        end
        @(posedge sys_clk) mode <= 3'h2;
        $display("t_mode done");
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        good_chk = src.rev8(8'b11010010);
        src.idle(2);
        repeat (12) @(posedge sys_clk);
        t_reset();
        rst_n <= 1'b1;
        src.idle(2);
        t_good();
        t_bad_check();
        t_bad_header();
        t_mode();
        print_verdict();
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
